// ===== design/prs_pkg.sv
`default_nettype none

package prs_pkg;

  // Setup values after reset: shortest access time, strobe in the six middle slots
  localparam logic [1:0] ACC_SEL_RESET = 2'h0;
  localparam logic [7:0] MASK_RESET = 8'h7e;
  localparam logic [23:0] ADDR_RESET = 24'h000000;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Access time codes, one per legal choice
  localparam logic [1:0] ACC_SEL_8 = 2'h0;
  localparam logic [1:0] ACC_SEL_16 = 2'h1;
  localparam logic [1:0] ACC_SEL_64 = 2'h2;
  localparam logic [1:0] ACC_SEL_256 = 2'h3;

  // Strobe slot length in clocks at or below 33 MHz; doubled above it
  localparam logic [6:0] SLOT_CYC_8 = 7'h01;
  localparam logic [6:0] SLOT_CYC_16 = 7'h02;
  localparam logic [6:0] SLOT_CYC_64 = 7'h08;
  localparam logic [6:0] SLOT_CYC_256 = 7'h20;
  localparam logic [2:0] SLOT_LAST = 3'h7;

  // Address shifter steps: six latch clock halves, one trailing low half, then done
  localparam logic [2:0] SHIFT_BYTE1 = 3'h2;
  localparam logic [2:0] SHIFT_BYTE2 = 3'h4;
  localparam logic [2:0] SHIFT_END = 3'h7;

  // Latch clock half period minus one: divide by two or by four
  localparam logic DIV_LAST_SLOW = 1'b0;
  localparam logic DIV_LAST_FAST = 1'b1;

  // Byte index of the last byte of a doubleword fetch
  localparam logic [1:0] DWORD_LAST = 2'h3;

  typedef enum logic [1:0] {PRS_IDLE, PRS_ADDR, PRS_ACCESS} prs_state_type;

endpackage : prs_pkg

`default_nettype wire

// ===== design/prs_addr_shifter.sv
`default_nettype none

module prs_addr_shifter (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic fastMode,
  input wire logic [23:0] addr,
  input wire logic [7:0] wrData,
  input wire logic driveData,
  output logic [7:0] busOut,
  output logic busOe,
  output logic latchClk,
  output logic aleN,
  output logic done
);

  typedef struct packed {
    logic active;
    logic [2:0] step;
    logic div;
    logic [23:0] hold;
    logic [7:0] bus;
    logic oe;
    logic clk;
    logic aleN;
    logic done;
  } prs_shift_type;

  prs_shift_type sh_reg, sh_next;
  logic tick;
  logic [2:0] stepNext;

  // One latch clock half has passed
  assign tick = sh_reg.div == (fastMode ? prs_pkg::DIV_LAST_FAST : prs_pkg::DIV_LAST_SLOW);
  assign stepNext = sh_reg.step + 3'h1;

  // Three bytes, high first, each latched by a rising latch clock
  always_comb
  begin
    sh_next = sh_reg;
    sh_next.done = 1'b0;
    if (go)
    begin
      sh_next.active = 1'b1;
      sh_next.step = 3'h0;
      sh_next.div = 1'b0;
      sh_next.hold = addr;
      sh_next.bus = addr[23:16];
      sh_next.oe = 1'b1;
      sh_next.clk = 1'b0;
      sh_next.aleN = 1'b0;
    end
    else if (sh_reg.active)
    begin
      sh_next.div = tick ? 1'b0 : 1'b1;
      if (tick)
      begin
        sh_next.step = stepNext;
        // Clock stays low in the trailing half so the last edge is a clean rise
        sh_next.clk = stepNext[0] && (stepNext != prs_pkg::SHIFT_END);
        if (stepNext == prs_pkg::SHIFT_BYTE1)
          sh_next.bus = sh_reg.hold[15:8];
        if (stepNext == prs_pkg::SHIFT_BYTE2)
          sh_next.bus = sh_reg.hold[7:0];
        if (stepNext == prs_pkg::SHIFT_END)
        begin
          sh_next.aleN = 1'b1;
          sh_next.active = 1'b0;
          sh_next.done = 1'b1;
          sh_next.oe = 1'b0;
        end
      end
    end
    else
    begin
      // Write data owns the bus between address phase and the end of access
      sh_next.oe = driveData;
      if (driveData)
        sh_next.bus = wrData;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sh_reg <= '{aleN: 1'b1, default: '0};
    else
      sh_reg <= sh_next;
  end

  assign busOut = sh_reg.bus;
  assign busOe = sh_reg.oe;
  assign latchClk = sh_reg.clk;
  assign aleN = sh_reg.aleN;
  assign done = sh_reg.done;

endmodule : prs_addr_shifter

`default_nettype wire

// ===== design/prs_strobe_timer.sv
`default_nettype none

module prs_strobe_timer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic isWrite,
  input wire logic fastMode,
  input wire logic [1:0] accSel,
  input wire logic [7:0] mask,
  output logic selN,
  output logic rdN,
  output logic wrN,
  output logic release_,
  output logic done
);

  typedef struct packed {
    logic active;
    logic [2:0] slot;
    logic [6:0] cnt;
    logic selN;
    logic rdN;
    logic wrN;
    logic rel;
    logic done;
  } prs_timer_type;

  prs_timer_type tm_reg, tm_next;
  logic [6:0] slotLen;
  logic [6:0] slotLast;
  logic strobeNext;

  // Slot length follows the access time, doubled above 33 MHz
  always_comb
  begin
    unique case (accSel)
      prs_pkg::ACC_SEL_8: slotLen = prs_pkg::SLOT_CYC_8;
      prs_pkg::ACC_SEL_16: slotLen = prs_pkg::SLOT_CYC_16;
      prs_pkg::ACC_SEL_64: slotLen = prs_pkg::SLOT_CYC_64;
      prs_pkg::ACC_SEL_256: slotLen = prs_pkg::SLOT_CYC_256;
    endcase
    if (fastMode)
      slotLen = {slotLen[5:0], 1'b0};
    slotLast = slotLen - 7'h01;
  end

  // Eight slots of select, strobe level per mask bit, bit 0 first
  always_comb
  begin
    tm_next = tm_reg;
    tm_next.done = 1'b0;
    strobeNext = 1'b0;
    if (go)
    begin
      tm_next.active = 1'b1;
      tm_next.slot = 3'h0;
      tm_next.cnt = 7'h00;
      tm_next.selN = 1'b0;
      strobeNext = mask[0];
    end
    else if (tm_reg.active)
    begin
      strobeNext = mask[tm_reg.slot];
      if (tm_reg.cnt == slotLast)
      begin
        tm_next.cnt = 7'h00;
        if (tm_reg.slot == prs_pkg::SLOT_LAST)
        begin
          tm_next.active = 1'b0;
          tm_next.selN = 1'b1;
          tm_next.done = 1'b1;
          strobeNext = 1'b0;
        end
        else
        begin
          tm_next.slot = tm_reg.slot + 3'h1;
          strobeNext = mask[tm_next.slot];
        end
      end
      else
        tm_next.cnt = tm_reg.cnt + 7'h01;
    end
    tm_next.rdN = !(strobeNext && !isWrite);
    tm_next.wrN = !(strobeNext && isWrite);
    // Marks the rising edge of the read strobe, where data is taken
    tm_next.rel = !tm_reg.rdN && tm_next.rdN;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tm_reg <= '{selN: 1'b1, rdN: 1'b1, wrN: 1'b1, default: '0};
    else
      tm_reg <= tm_next;
  end

  assign selN = tm_reg.selN;
  assign rdN = tm_reg.rdN;
  assign wrN = tm_reg.wrN;
  assign release_ = tm_reg.rel;
  assign done = tm_reg.done;

endmodule : prs_strobe_timer

`default_nettype wire

// ===== design/prs_rom_sequencer.sv
// Functional notes
// - Address goes out as three bytes, high first, each latched by a rising clock.
// - Latch enable low from first byte until third is clocked, then high before select.
// - Read: select and read strobe per mask, byte sampled, strobe and select released.
// - Write: data driven after address, select and write strobe per mask.
// - Parallel start bit clears when the register-driven bus cycle ends.
// - Window reads are delayed reads answered first with a retry.
// - Window read does four byte reads; the dword returns on the matching retry.
// - Busy bit sets when a window fetch starts and clears when it ends.
// - The window address is kept in the address register for retry matching.
// - A new offset after a finished fetch discards it and queues the new one.
// - A new offset while the fetch still runs gets a retry.
// - Access time is one of four lengths, doubled above 33 MHz.
// - Select stays low exactly the access time, first slot to last.
// - Access time resets to its shortest setting.
// - Eight mask bits shape the strobe, one per eighth, bit 0 first.
// - Slot length is an eighth of the access time for the clock range.
// - Mask resets with the strobe off in the first and last slots.
// - Latch clock runs at the clock over two, or over four when fast.
// - Read data is taken where the read strobe rises.

`default_nettype none

module prs_rom_sequencer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic fastMode,
  input wire logic regStartPulse,
  input wire logic regSerialStart,
  input wire logic regWriteCtl,
  input wire logic regAddrWe,
  input wire logic [23:0] regAddrIn,
  input wire logic regDataWe,
  input wire logic [7:0] regDataIn,
  input wire logic setupWe,
  input wire logic [1:0] setupAccessIn,
  input wire logic [7:0] setupMaskIn,
  input wire logic winReq,
  input wire logic [23:0] winAddr,
  input wire logic [7:0] romMuxBusIn,
  output logic parallelStartBit,
  output logic [23:0] romAddrOut,
  output logic [7:0] romDataOut,
  output logic [1:0] accessSelOut,
  output logic [7:0] strobeMaskOut,
  output logic winRetry,
  output logic winAck,
  output logic [31:0] winData,
  output logic [7:0] romMuxBusOut,
  output logic romMuxBusOe,
  output logic addrLatchEnableN,
  output logic addrLatchClock,
  output logic romSelectN,
  output logic romReadStrobeN,
  output logic romWriteStrobeN
);

  typedef struct packed {
    prs_pkg::prs_state_type st;
    logic busy;
    logic isWrite;
    logic isWin;
    logic winDone;
    logic [1:0] byteCnt;
    logic [23:0] romAddr;
    logic [7:0] romData;
    logic [1:0] accSel;
    logic [7:0] mask;
    logic [31:0] dword;
    logic shiftGo;
    logic timeGo;
    logic driveData;
    logic retry;
    logic ack;
    logic [31:0] ackData;
    logic [7:0] sync1;
    logic [7:0] sync2;
  } prs_seq_type;

  prs_seq_type seq_reg, seq_next;
  logic regGo;
  logic winHit;
  logic [23:0] shiftAddr;
  logic shiftDone;
  logic timeDone;
  logic strobeRelease;

  // Register start only counts for a parallel access while the port is idle
  assign regGo = regStartPulse && !regSerialStart && (seq_reg.st == prs_pkg::PRS_IDLE);

  // A retry matches the stored doubleword address of a finished fetch
  assign winHit = seq_reg.winDone && (winAddr[23:2] == seq_reg.romAddr[23:2]);

  // Window fetch walks up from the aligned offset
  assign shiftAddr = seq_reg.isWin ? {seq_reg.romAddr[23:2], seq_reg.byteCnt} : seq_reg.romAddr;

  prs_addr_shifter u_shift (
    .mclk(mclk),
    .rst_n(rst_n),
    .go(seq_reg.shiftGo),
    .fastMode(fastMode),
    .addr(shiftAddr),
    .wrData(seq_reg.romData),
    .driveData(seq_reg.driveData),
    .busOut(romMuxBusOut),
    .busOe(romMuxBusOe),
    .latchClk(addrLatchClock),
    .aleN(addrLatchEnableN),
    .done(shiftDone)
  );

  prs_strobe_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .go(seq_reg.timeGo),
    .isWrite(seq_reg.isWrite),
    .fastMode(fastMode),
    .accSel(seq_reg.accSel),
    .mask(seq_reg.mask),
    .selN(romSelectN),
    .rdN(romReadStrobeN),
    .wrN(romWriteStrobeN),
    .release_(strobeRelease),
    .done(timeDone)
  );

  // Sequencer: register byte access or four-byte window fetch, plus delayed-read answers
  always_comb
  begin
    seq_next = seq_reg;
    seq_next.shiftGo = 1'b0;
    seq_next.timeGo = 1'b0;
    seq_next.retry = 1'b0;
    seq_next.ack = 1'b0;
    // The bus is read only through the second stage of the synchroniser
    seq_next.sync1 = romMuxBusIn;
    seq_next.sync2 = seq_reg.sync1;
    if (setupWe)
    begin
      seq_next.accSel = setupAccessIn;
      seq_next.mask = setupMaskIn;
    end
    // Software may clobber the stored window address; that is its own hazard
    if (regAddrWe)
      seq_next.romAddr = regAddrIn;
    if (regDataWe)
      seq_next.romData = regDataIn;
    unique case (seq_reg.st)
      prs_pkg::PRS_IDLE:
      begin
        if (regGo)
        begin
          seq_next.busy = 1'b1;
          seq_next.isWrite = regWriteCtl;
          seq_next.isWin = 1'b0;
          seq_next.shiftGo = 1'b1;
          seq_next.st = prs_pkg::PRS_ADDR;
        end
      end
      prs_pkg::PRS_ADDR:
      begin
        // Select and strobes wait for the latch enable to go high
        if (shiftDone)
        begin
          seq_next.timeGo = 1'b1;
          seq_next.driveData = seq_reg.isWrite;
          seq_next.st = prs_pkg::PRS_ACCESS;
        end
      end
      prs_pkg::PRS_ACCESS:
      begin
        if (strobeRelease && !seq_reg.isWrite)
        begin
          if (seq_reg.isWin)
            seq_next.dword[{seq_reg.byteCnt, 3'h0} +: 8] = seq_reg.sync2;
          else
            seq_next.romData = seq_reg.sync2;
        end
        if (timeDone)
        begin
          seq_next.driveData = 1'b0;
          if (seq_reg.isWin && (seq_reg.byteCnt != prs_pkg::DWORD_LAST))
          begin
            // Next byte of the doubleword
            seq_next.byteCnt = seq_reg.byteCnt + 2'h1;
            seq_next.shiftGo = 1'b1;
            seq_next.st = prs_pkg::PRS_ADDR;
          end
          else
          begin
            seq_next.busy = 1'b0;
            seq_next.winDone = seq_reg.isWin;
            seq_next.st = prs_pkg::PRS_IDLE;
          end
        end
      end
      default:
        seq_next.st = prs_pkg::PRS_IDLE;
    endcase
    // Window reads: one pending requester, a register start takes precedence
    if (winReq)
    begin
      if (winHit)
      begin
        seq_next.ack = 1'b1;
        seq_next.ackData = seq_reg.dword;
        seq_next.winDone = 1'b0;
      end
      else if ((seq_reg.st != prs_pkg::PRS_IDLE) || regGo)
        seq_next.retry = 1'b1;
      else
      begin
        // New or different offset: drop any finished result and fetch
        seq_next.retry = 1'b1;
        seq_next.winDone = 1'b0;
        seq_next.romAddr = {winAddr[23:2], 2'h0};
        seq_next.isWin = 1'b1;
        seq_next.isWrite = 1'b0;
        seq_next.busy = 1'b1;
        seq_next.byteCnt = 2'h0;
        seq_next.shiftGo = 1'b1;
        seq_next.st = prs_pkg::PRS_ADDR;
      end
    end
  end

  // Setup defaults after reset
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      seq_reg <= '{st: prs_pkg::PRS_IDLE, accSel: prs_pkg::ACC_SEL_RESET,
                   mask: prs_pkg::MASK_RESET, romAddr: prs_pkg::ADDR_RESET,
                   romData: prs_pkg::DATA_RESET, default: '0};
    else
      seq_reg <= seq_next;
  end

  assign parallelStartBit = seq_reg.busy;
  assign romAddrOut = seq_reg.romAddr;
  assign romDataOut = seq_reg.romData;
  assign accessSelOut = seq_reg.accSel;
  assign strobeMaskOut = seq_reg.mask;
  assign winRetry = seq_reg.retry;
  assign winAck = seq_reg.ack;
  assign winData = seq_reg.ackData;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // High address byte appears with the latch enable the cycle after a start
  property p_addr_first_byte;
    seq_reg.shiftGo |=> !addrLatchEnableN && (romMuxBusOut == $past(shiftAddr[23:16]))
      && !addrLatchClock;
  endproperty
  a_addr_first_byte: assert property (p_addr_first_byte) else $error("bad first address byte");

  // Latch enable and chip select never overlap
  property p_ale_no_select;
    !addrLatchEnableN |-> romSelectN && romReadStrobeN && romWriteStrobeN;
  endproperty
  a_ale_no_select: assert property (p_ale_no_select) else $error("select during address");

  // Default setup at the slow clock: select low for eight cycles, then high
  sequence s_select_held;
    !romSelectN [*8] ##1 romSelectN;
  endsequence
  property p_select_length;
    ($fell(romSelectN) && !fastMode && (seq_reg.accSel == prs_pkg::ACC_SEL_8))
      |-> s_select_held;
  endproperty
  a_select_length: assert property (p_select_length) else $error("select length wrong");

  // A strobe is only asserted while selected
  property p_strobe_in_select;
    (!romReadStrobeN || !romWriteStrobeN) |-> !romSelectN;
  endproperty
  a_strobe_in_select: assert property (p_strobe_in_select) else $error("strobe outside select");

  // Start bit falls only as the access timer finishes
  property p_start_clears;
    $fell(parallelStartBit) |-> $past(timeDone);
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start bit cleared early");

  // A window read to an idle port is retried and makes the port busy
  property p_win_first_retry;
    (winReq && !winHit && !regGo && (seq_reg.st == prs_pkg::PRS_IDLE))
      |=> winRetry && parallelStartBit ##1 !addrLatchEnableN;
  endproperty
  a_win_first_retry: assert property (p_win_first_retry) else $error("window read not queued");

  // A miss while the fetch runs is retried and never answered
  property p_busy_retry;
    (winReq && !winHit && (seq_reg.st != prs_pkg::PRS_IDLE)) |=> winRetry && !winAck;
  endproperty
  a_busy_retry: assert property (p_busy_retry) else $error("busy miss not retried");

  // Answer carries the fetched doubleword
  property p_ack_data;
    winAck |-> (winData == $past(seq_reg.dword)) && !winRetry;
  endproperty
  a_ack_data: assert property (p_ack_data) else $error("window answer data wrong");

  // Read data is taken from the synchronised bus at the strobe release
  property p_capture;
    (strobeRelease && !seq_reg.isWrite && !seq_reg.isWin && (seq_reg.st == prs_pkg::PRS_ACCESS))
      |=> romDataOut == $past(seq_reg.sync2);
  endproperty
  a_capture: assert property (p_capture) else $error("read byte not captured");

  // Latch clock stays low for two cycles after each fall in fast mode
  property p_latch_div;
    ($fell(addrLatchClock) && fastMode) |-> !addrLatchClock [*2];
  endproperty
  a_latch_div: assert property (p_latch_div) else $error("latch clock too fast");

endmodule : prs_rom_sequencer

`default_nettype wire

// ===== verification/prs_rom_model.sv
`default_nettype none

module prs_rom_model (
  input wire logic mclk,
  input wire logic [7:0] busIn,
  input wire logic aleN,
  input wire logic latchClk,
  input wire logic selN,
  input wire logic rdN,
  input wire logic wrN,
  output logic [7:0] romOut,
  output logic romOe,
  output logic [23:0] latAddr
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] mem [0:255];
  logic wrPrev;

  // Pattern the bench can recompute; only the low address byte selects a cell
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'ha5;
    wrPrev = 1'b1;
    latAddr = 24'h000000;
  end

  // Three octal latches in a chain, clocked only while enabled
  always @(posedge latchClk)
  begin
    if (!aleN)
      latAddr <= {latAddr[15:0], busIn};
  end

  // Drives only while selected and output enabled; otherwise the bench shows the inverse of the last bus level
  assign romOe = !selN && !rdN;
  assign romOut = mem[latAddr[7:0]];

  // Takes the byte where the write strobe rises while still selected
  always @(posedge mclk)
  begin
    wrPrev <= wrN;
    if (wrN && !wrPrev && !selN)
      mem[latAddr[7:0]] <= busIn;
  end
endmodule : prs_rom_model

`default_nettype wire

// ===== verification/prs_rom_sequencer_tb.sv
`default_nettype none

module prs_rom_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk, rst_n, fastMode, regStartPulse, regSerialStart, regWriteCtl, regAddrWe;
  logic regDataWe, setupWe, winReq, parallelStartBit, winRetry, winAck, romMuxBusOe;
  logic addrLatchEnableN, addrLatchClock, romSelectN, romReadStrobeN, romWriteStrobeN;
  logic [23:0] regAddrIn, winAddr, romAddrOut, latAddr;
  logic [7:0] regDataIn, setupMaskIn, romDataOut, strobeMaskOut, romMuxBusOut;
  logic [7:0] busIn, romOut;
  // Starts at a known level so a released bus never floats unknown
  logic [7:0] lastBus = 8'h00;
  logic [1:0] setupAccessIn, accessSelOut;
  logic [31:0] winData;
  logic romOe;
  int nMismatch = 0, nTests = 0;
  int selCnt = 0, rdCnt = 0, clkCnt = 0, selLen = 0, rdLen = 0, clkLen = 0;
  int wrCnt = 0, wrLen = 0;

  // Released bus shows the inverse of its last level, never a kind value
  assign busIn = romMuxBusOe ? romMuxBusOut : (romOe ? romOut : ~lastBus);

  prs_rom_sequencer uut (.mclk(mclk), .rst_n(rst_n), .fastMode(fastMode),
    .regStartPulse(regStartPulse), .regSerialStart(regSerialStart),
    .regWriteCtl(regWriteCtl), .regAddrWe(regAddrWe), .regAddrIn(regAddrIn),
    .regDataWe(regDataWe), .regDataIn(regDataIn), .setupWe(setupWe),
    .setupAccessIn(setupAccessIn), .setupMaskIn(setupMaskIn), .winReq(winReq),
    .winAddr(winAddr), .romMuxBusIn(busIn), .parallelStartBit(parallelStartBit),
    .romAddrOut(romAddrOut), .romDataOut(romDataOut), .accessSelOut(accessSelOut),
    .strobeMaskOut(strobeMaskOut), .winRetry(winRetry), .winAck(winAck),
    .winData(winData), .romMuxBusOut(romMuxBusOut), .romMuxBusOe(romMuxBusOe),
    .addrLatchEnableN(addrLatchEnableN), .addrLatchClock(addrLatchClock),
    .romSelectN(romSelectN), .romReadStrobeN(romReadStrobeN),
    .romWriteStrobeN(romWriteStrobeN));

  prs_rom_model rom (.mclk(mclk), .busIn(busIn), .aleN(addrLatchEnableN),
    .latchClk(addrLatchClock), .selN(romSelectN), .rdN(romReadStrobeN),
    .wrN(romWriteStrobeN), .romOut(romOut), .romOe(romOe), .latAddr(latAddr));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Width of the latest select, read strobe and latch clock pulse, in clocks
  always @(posedge mclk)
  begin
    lastBus <= busIn;
    selCnt <= romSelectN ? 0 : selCnt + 1;
    rdCnt <= romReadStrobeN ? 0 : rdCnt + 1;
    wrCnt <= romWriteStrobeN ? 0 : wrCnt + 1;
    if (!romWriteStrobeN) wrLen <= wrCnt + 1;
    clkCnt <= addrLatchClock ? clkCnt + 1 : 0;
    if (!romSelectN) selLen <= selCnt + 1;
    if (!romReadStrobeN) rdLen <= rdCnt + 1;
    if (addrLatchClock) clkLen <= clkCnt + 1;
  end

  function automatic logic [31:0] dword(input logic [23:0] a);
    logic [7:0] b;
    b = {a[7:2], 2'h0};
    return {(b + 8'h03) ^ 8'ha5, (b + 8'h02) ^ 8'ha5, (b + 8'h01) ^ 8'ha5, b ^ 8'ha5};
  endfunction : dword

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", nTests, nMismatch);
    if (nMismatch == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task automatic tick();
    @(posedge mclk);
    #10;
  endtask : tick

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  // Bounded poll of the busy bit; a hang ends the run
  task automatic waitIdle();
    int k;
    k = 0;
    while (parallelStartBit !== 1'b0 && k < 3000)
    begin
      tick();
      k++;
    end
    if (k == 3000)
    begin
      chk("busy poll", 32'h0, 32'h1);
      summarize();
    end
  endtask : waitIdle

  task automatic setup(input logic fast, input logic [1:0] acc, input logic [7:0] mask);
    fastMode = fast;
    setupAccessIn = acc;
    setupMaskIn = mask;
    setupWe = 1'b1;
    tick();
    setupWe = 1'b0;
    tick();
    chk("accessSel", 32'(acc), 32'(accessSelOut));
    chk("strobeMask", 32'(mask), 32'(strobeMaskOut));
  endtask : setup

  // Loads address and data, starts, sees busy rise, then polls it down
  task automatic regOp(input logic wr, input logic [23:0] a, input logic [7:0] d);
    regAddrIn = a;
    regDataIn = d;
    regAddrWe = 1'b1;
    regDataWe = 1'b1;
    tick();
    regAddrWe = 1'b0;
    regDataWe = 1'b0;
    regWriteCtl = wr;
    regSerialStart = 1'b0;
    regStartPulse = 1'b1;
    tick();
    regStartPulse = 1'b0;
    @(posedge mclk);
    #1;
    chk("busy set", 32'h1, 32'(parallelStartBit));
    #9;
    waitIdle();
    chk("latched address", 32'(a), 32'(latAddr));
  endtask : regOp

  task automatic winTry(input logic [23:0] a, input logic retry, input logic [31:0] d);
    winAddr = a;
    winReq = 1'b1;
    tick();
    winReq = 1'b0;
    // The answer pulse stands only in the cycle right after the request edge
    chk("winRetry", 32'(retry), 32'(winRetry));
    chk("winAck", 32'(!retry), 32'(winAck));
    if (!retry)
      chk("winData", d, winData);
    tick();
  endtask : winTry

  task automatic t_reset();
    chk("accessSel reset", 32'(prs_pkg::ACC_SEL_8), 32'(accessSelOut));
    chk("mask reset", 32'h7e, 32'(strobeMaskOut));
    chk("idle lines", 32'h3, {29'h0, romMuxBusOe, addrLatchEnableN, romSelectN});
  endtask : t_reset

  task automatic t_write_read();
    setup(1'b0, prs_pkg::ACC_SEL_8, 8'h7e);
    regOp(1'b1, 24'h123456, 8'hc3);
    chk("write select", 32'd8, 32'(selLen));
    chk("write strobe", 32'd6, 32'(wrLen));
    regOp(1'b0, 24'h123456, 8'h00);
    chk("read back", 32'hc3, 32'(romDataOut));
    chk("read strobe", 32'd6, 32'(rdLen));
    chk("latch clock high", 32'd1, 32'(clkLen));
  endtask : t_write_read

  // Every access code, slow and one fast, with a four-slot strobe
  task automatic t_timing();
    logic [1:0] accs [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
    int lens [5] = '{8, 16, 64, 256, 32};
    for (int i = 0; i < 5; i++)
    begin
      setup(i == 4, accs[i], 8'h3c);
      regOp(1'b0, 24'h000020 + 24'(i), 8'h00);
      chk("select length", 32'(lens[i]), 32'(selLen));
      chk("strobe length", 32'(lens[i] / 2), 32'(rdLen));
      chk("read data", 32'((8'h20 + 8'(i)) ^ 8'ha5), 32'(romDataOut));
      chk("latch clock high", (i == 4) ? 32'd2 : 32'd1, 32'(clkLen));
    end
    setup(1'b0, prs_pkg::ACC_SEL_8, 8'h7e);
  endtask : t_timing

  task automatic t_serial();
    regSerialStart = 1'b1;
    regStartPulse = 1'b1;
    tick();
    regStartPulse = 1'b0;
    @(posedge mclk);
    #1;
    chk("serial start ignored", 32'h0, 32'(parallelStartBit));
    #9;
  endtask : t_serial

  task automatic t_window();
    winTry(24'h000041, 1'b1, 32'h0);
    chk("window busy", 32'h1, 32'(parallelStartBit));
    winTry(24'h000080, 1'b1, 32'h0);
    waitIdle();
    winTry(24'h000042, 1'b0, dword(24'h000040));
    chk("kept address", 32'(22'h000010), 32'(romAddrOut[23:2]));
    winTry(24'h000060, 1'b1, 32'h0);
    waitIdle();
    winTry(24'h000090, 1'b1, 32'h0);
    waitIdle();
    winTry(24'h000093, 1'b0, dword(24'h000090));
  endtask : t_window

  initial
  begin
    rst_n = 1'b0;
    fastMode = 1'b0;
    regStartPulse = 1'b0;
    regSerialStart = 1'b0;
    regWriteCtl = 1'b0;
    regAddrWe = 1'b0;
    regAddrIn = 24'h000000;
    regDataWe = 1'b0;
    regDataIn = 8'h00;
    setupWe = 1'b0;
    setupAccessIn = 2'h0;
    setupMaskIn = 8'h7e;
    winReq = 1'b0;
    winAddr = 24'h000000;
    repeat (4) @(posedge mclk);
    #10;
    rst_n = 1'b1;
    t_reset();
    t_write_read();
    t_timing();
    t_serial();
    t_window();
    summarize();
  end
endmodule : prs_rom_sequencer_tb

`default_nettype wire
